// File: rtl/fec_regs.svh
// Register offsets, field positions, reset values, command codes and
// bus cycle timing for the flash erase host controller.
// Assumes a 32-bit APB register bus and a 250 MHz system clock.
`ifndef FEC_REGS_SVH
`define FEC_REGS_SVH

`define FEC_OFF_CTRL 12'h000
`define FEC_OFF_ADDR 12'h004
`define FEC_OFF_DATA 12'h008
`define FEC_OFF_CFG 12'h00C
`define FEC_OFF_STAT 12'h010
`define FEC_OFF_RDATA 12'h014

`define FEC_CTRL_OP_LSB 0
`define FEC_CFG_WP_HIGH 0
`define FEC_CFG_HV_ON 1
`define FEC_CFG_TOP_BLK 2
`define FEC_CFG_RST 3'h1
`define FEC_ST_BUSY 0
`define FEC_ST_REFUSED 1
`define FEC_ST_TIMER 2
`define FEC_ST_MODE_LSB 4

`define FEC_CMD_ERASE_SETUP 8'h80
`define FEC_CMD_BLK_ERASE 8'h30
`define FEC_CMD_CHIP_ERASE 8'h10
`define FEC_CMD_SUSPEND 8'hB0
`define FEC_CMD_RESUME 8'h30
`define FEC_CMD_BLANK_A 8'hEB
`define FEC_CMD_BLANK_B 8'h76
`define FEC_CMD_BLANK_C 8'h29
`define FEC_TIMER_DQ 3

`define FEC_CLK_MHZ 250
`define FEC_T_PULSE_NS 70
`define FEC_T_REC_NS 20
`define FEC_PULSE_CYC ((`FEC_T_PULSE_NS * `FEC_CLK_MHZ + 999) / 1000)
`define FEC_REC_CYC ((`FEC_T_REC_NS * `FEC_CLK_MHZ + 999) / 1000)

`endif

// File: rtl/fec_pkg.sv
// Types shared by the flash erase host controller and its bus cycle engine.
// Assumes nothing beyond the header of constants.
package fec_pkg;

  typedef enum logic [3:0] {
    FEC_OP_NONE, FEC_OP_ERASE_FIRST, FEC_OP_ERASE_ADD, FEC_OP_SUSPEND,
    FEC_OP_RESUME, FEC_OP_BLANK, FEC_OP_CHIP, FEC_OP_RESET, FEC_OP_READ,
    FEC_OP_RAW
  } fec_op_e;

  typedef enum logic [2:0] {
    FEC_M_READ, FEC_M_SELECT, FEC_M_ERASING, FEC_M_SUSPENDED, FEC_M_CHIP,
    FEC_M_BLANK
  } fec_mode_e;

  typedef struct packed {
    logic rd;
    logic [23:0] addr;
    logic [15:0] data;
  } fec_req_s;

  typedef struct packed {
    logic last;
    logic rd;
    logic use_blk;
    logic [15:0] data;
  } fec_step_s;

endpackage : fec_pkg

// File: rtl/fec_bus_cycle.sv
// One asynchronous flash bus cycle (read or write) per request.
// Assumes the flash data inputs are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"

module fec_bus_cycle
  import fec_pkg::*;
#(
  parameter int PULSE_CYC = `FEC_PULSE_CYC,
  parameter int REC_CYC = `FEC_REC_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  input wire fec_req_s req,
  output logic ack_ff,
  output logic [15:0] rdata_ff,
  // Flash pins
  output logic [23:0] fl_addr_ff,
  output logic [15:0] fl_dq_o_ff,
  input wire logic [15:0] fl_dq_i,
  output logic fl_dq_oe_n_ff,
  output logic fl_ce_n_ff,
  output logic fl_we_n_ff,
  output logic fl_oe_n_ff
);

  typedef enum logic [1:0] {FEC_C_IDLE, FEC_C_SETUP, FEC_C_PULSE,
    FEC_C_REC} fec_cyc_e;

  fec_cyc_e state_ff;
  logic [7:0] cnt_ff;
  logic rd_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= FEC_C_IDLE;
      cnt_ff <= 8'h00;
      rd_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
      fl_addr_ff <= 24'h000000;
      fl_dq_o_ff <= 16'h0000;
      fl_dq_oe_n_ff <= 1'b1;
      fl_ce_n_ff <= 1'b1;
      fl_we_n_ff <= 1'b1;
      fl_oe_n_ff <= 1'b1;
    end else begin
      ack_ff <= 1'b0;
      case (state_ff)
        FEC_C_IDLE: begin
          if (req_valid) begin
            rd_ff <= req.rd;
            fl_addr_ff <= req.addr;
            fl_dq_o_ff <= req.data;
            fl_dq_oe_n_ff <= req.rd;
            fl_ce_n_ff <= 1'b0;
            state_ff <= FEC_C_SETUP;
          end
        end
        FEC_C_SETUP: begin
          fl_we_n_ff <= rd_ff;
          fl_oe_n_ff <= ~rd_ff;
          cnt_ff <= 8'(PULSE_CYC - 1);
          state_ff <= FEC_C_PULSE;
        end
        FEC_C_PULSE: begin
          if (cnt_ff == 8'h00) begin
            // Sample at the end of the strobe, after the access time
            if (rd_ff) begin
              rdata_ff <= fl_dq_i;
            end
            fl_we_n_ff <= 1'b1;
            fl_oe_n_ff <= 1'b1;
            fl_ce_n_ff <= 1'b1;
            cnt_ff <= 8'(REC_CYC - 1);
            state_ff <= FEC_C_REC;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        FEC_C_REC: begin
          // Data stays driven through recovery to cover write hold time
          if (cnt_ff == 8'h00) begin
            fl_dq_oe_n_ff <= 1'b1;
            ack_ff <= 1'b1;
            state_ff <= FEC_C_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        default: state_ff <= FEC_C_IDLE;
      endcase
    end
  end

endmodule : fec_bus_cycle
`default_nettype wire

// File: rtl/fec_host.sv
// Host controller that drives a parallel NOR flash erase engine through
// its pins, taking orders from software over APB.
// Assumes the flash is already in bypass mode (or high voltage applied)
// and that flash inputs are synchronous to sys_clk.
// Operation
// - Bypass block erase is two writes; second carries block address.
// - More blocks are queued by repeating the second write per block.
// - Suspend is one write of the suspend code, address ignored.
// - Host leaves special modes with read/reset before resuming.
// - Blank check is three writes (EB, 76, 29) to the block, one block each.
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"

module fec_host
  import fec_pkg::*;
#(
  parameter int BLK_SHIFT = 16,
  parameter logic [7:0] RESET_CODE = 8'hF0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata_ff,
  output logic pready_ff,
  output logic pslverr_ff,
  // Flash pins
  output logic [23:0] fl_addr_ff,
  output logic [15:0] fl_dq_o_ff,
  input wire logic [15:0] fl_dq_i,
  output logic fl_dq_oe_n_ff,
  output logic fl_ce_n_ff,
  output logic fl_we_n_ff,
  output logic fl_oe_n_ff,
  output logic fl_wp_high_ff,
  output logic fl_high_program_voltage_ff
);

  // Command sequence for each operation, one entry per bus cycle
  function automatic fec_step_s op_step(fec_op_e op, logic [1:0] idx,
      logic [15:0] raw, logic [7:0] rcode);
    fec_step_s s;
    s = '{last: 1'b1, rd: 1'b0, use_blk: 1'b0, data: 16'h0000};
    case (op)
      FEC_OP_ERASE_FIRST: begin
        s.last = (idx == 2'd1);
        s.use_blk = (idx == 2'd1);
        s.data = {8'h00, (idx == 2'd0) ? `FEC_CMD_ERASE_SETUP
          : `FEC_CMD_BLK_ERASE};
      end
      FEC_OP_ERASE_ADD: begin
        s.use_blk = 1'b1;
        s.data = {8'h00, `FEC_CMD_BLK_ERASE};
      end
      FEC_OP_SUSPEND: s.data = {8'h00, `FEC_CMD_SUSPEND};
      FEC_OP_RESUME: begin
        // Read/reset first so the device sits in read array mode
        s.last = (idx == 2'd1);
        s.data = {8'h00, (idx == 2'd0) ? rcode : `FEC_CMD_RESUME};
      end
      FEC_OP_BLANK: begin
        s.last = (idx == 2'd2);
        s.use_blk = 1'b1;
        s.data = {8'h00, (idx == 2'd0) ? `FEC_CMD_BLANK_A
          : (idx == 2'd1) ? `FEC_CMD_BLANK_B : `FEC_CMD_BLANK_C};
      end
      FEC_OP_CHIP: begin
        s.last = (idx == 2'd1);
        s.data = {8'h00, (idx == 2'd0) ? `FEC_CMD_ERASE_SETUP
          : `FEC_CMD_CHIP_ERASE};
      end
      FEC_OP_RESET: s.data = {8'h00, rcode};
      FEC_OP_READ: begin
        s.rd = 1'b1;
        s.use_blk = 1'b1;
      end
      FEC_OP_RAW: begin
        s.use_blk = 1'b1;
        s.data = raw;
      end
      default: s = '{last: 1'b1, rd: 1'b1, use_blk: 1'b0, data: 16'h0000};
    endcase
    return s;
  endfunction : op_step

  logic [3:0] op_ff;
  logic [1:0] idx_ff;
  logic busy_ff;
  logic issue_ff;
  logic refused_ff;
  logic timer_ff;
  logic [23:0] addr_ff;
  logic [15:0] data_ff;
  logic [2:0] cfg_ff;
  fec_mode_e mode_ff;
  logic [15:0] rword;
  logic ack;
  fec_req_s req;
  fec_step_s step;
  fec_op_e cur_op;
  fec_op_e new_op;
  logic acc_wr;
  logic start_ok;
  logic boundary;

  assign cur_op = fec_op_e'(op_ff);
  assign new_op = fec_op_e'(pwdata[`FEC_CTRL_OP_LSB +: 4]);
  assign acc_wr = psel & penable & pwrite & ~pready_ff;
  assign step = op_step(cur_op, idx_ff, data_ff, RESET_CODE);
  assign boundary = cfg_ff[`FEC_CFG_TOP_BLK]
    ? (&addr_ff[23:BLK_SHIFT]) : (addr_ff[23:BLK_SHIFT] == '0);

  always_comb begin
    req.rd = step.rd;
    req.addr = step.use_blk ? addr_ff : 24'h000000;
    req.data = step.data;
  end

  // Which orders the flash can take in its present state
  always_comb begin
    start_ok = 1'b0;
    case (mode_ff)
      FEC_M_READ: start_ok = (new_op != FEC_OP_ERASE_ADD)
        && (new_op != FEC_OP_SUSPEND) && (new_op != FEC_OP_RESUME)
        && ((new_op != FEC_OP_CHIP) || cfg_ff[`FEC_CFG_HV_ON]);
      FEC_M_SELECT: start_ok = (new_op == FEC_OP_SUSPEND)
        || (new_op == FEC_OP_READ) || (new_op == FEC_OP_RESET)
        || ((new_op == FEC_OP_ERASE_ADD) && !timer_ff);
      FEC_M_ERASING: start_ok = (new_op == FEC_OP_SUSPEND)
        || (new_op == FEC_OP_READ) || (new_op == FEC_OP_RESET);
      FEC_M_SUSPENDED: start_ok = (new_op != FEC_OP_ERASE_FIRST)
        && (new_op != FEC_OP_ERASE_ADD) && (new_op != FEC_OP_SUSPEND)
        && (new_op != FEC_OP_BLANK) && (new_op != FEC_OP_CHIP);
      FEC_M_CHIP, FEC_M_BLANK: start_ok = (new_op == FEC_OP_READ)
        || (new_op == FEC_OP_RESET);
      default: start_ok = 1'b0;
    endcase
    // Boundary block: refused while FEC_CFG_WP_HIGH is clear; the flash drops the erase only if FEC_CFG_HV_ON is clear too
    if (((new_op == FEC_OP_ERASE_FIRST) || (new_op == FEC_OP_ERASE_ADD))
        && boundary && !cfg_ff[`FEC_CFG_WP_HIGH]) begin
      start_ok = 1'b0;
    end
    if (new_op == FEC_OP_NONE) begin
      start_ok = 1'b0;
    end
  end

  // Order intake and sequencing
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_ff <= 4'h0;
      idx_ff <= 2'd0;
      busy_ff <= 1'b0;
      issue_ff <= 1'b0;
    end else begin
      issue_ff <= 1'b0;
      if (!busy_ff && acc_wr && paddr == `FEC_OFF_CTRL && start_ok) begin
        op_ff <= new_op;
        idx_ff <= 2'd0;
        busy_ff <= 1'b1;
        issue_ff <= 1'b1;
      end else if (busy_ff && ack) begin
        if (step.last) begin
          busy_ff <= 1'b0;
        end else begin
          idx_ff <= idx_ff + 2'd1;
          issue_ff <= 1'b1;
        end
      end
    end
  end

  // Host view of the flash state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= FEC_M_READ;
      timer_ff <= 1'b0;
    end else if (busy_ff && ack && step.last) begin
      case (cur_op)
        FEC_OP_ERASE_FIRST: begin
          mode_ff <= FEC_M_SELECT;
          timer_ff <= 1'b0;
        end
        FEC_OP_ERASE_ADD: timer_ff <= 1'b0;
        FEC_OP_SUSPEND: mode_ff <= FEC_M_SUSPENDED;
        FEC_OP_RESUME: mode_ff <= FEC_M_ERASING;
        FEC_OP_BLANK: mode_ff <= FEC_M_BLANK;
        FEC_OP_CHIP: mode_ff <= FEC_M_CHIP;
        FEC_OP_RESET: begin
          // Ends a failed or finished operation; ignored while suspended
          if (mode_ff != FEC_M_SUSPENDED) begin
            mode_ff <= FEC_M_READ;
          end
        end
        FEC_OP_READ: begin
          timer_ff <= rword[`FEC_TIMER_DQ];
          if (mode_ff == FEC_M_SELECT && rword[`FEC_TIMER_DQ]) begin
            mode_ff <= FEC_M_ERASING;
          end
        end
        default: mode_ff <= mode_ff;
      endcase
    end
  end

  // Software registers; a refusal in the clearing cycle still sets the flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_ff <= 24'h000000;
      data_ff <= 16'h0000;
      cfg_ff <= `FEC_CFG_RST;
      refused_ff <= 1'b0;
      fl_wp_high_ff <= 1'b1;
      fl_high_program_voltage_ff <= 1'b0;
    end else begin
      if (acc_wr && paddr == `FEC_OFF_ADDR && !busy_ff) begin
        addr_ff <= pwdata[23:0];
      end
      if (acc_wr && paddr == `FEC_OFF_DATA && !busy_ff) begin
        data_ff <= pwdata[15:0];
      end
      if (acc_wr && paddr == `FEC_OFF_CFG) begin
        cfg_ff <= pwdata[2:0];
      end
      if (acc_wr && paddr == `FEC_OFF_CTRL && (busy_ff || !start_ok)) begin
        refused_ff <= 1'b1;
      end else if (acc_wr && paddr == `FEC_OFF_STAT
          && pwdata[`FEC_ST_REFUSED]) begin
        refused_ff <= 1'b0;
      end
      fl_wp_high_ff <= cfg_ff[`FEC_CFG_WP_HIGH] | cfg_ff[`FEC_CFG_HV_ON];
      fl_high_program_voltage_ff <= cfg_ff[`FEC_CFG_HV_ON];
    end
  end

  // APB answer: one wait state, then pready with data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= psel & penable & ~pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      if (psel && penable && !pready_ff) begin
        case (paddr)
          `FEC_OFF_CTRL: prdata_ff <= {28'h0000000, op_ff};
          `FEC_OFF_ADDR: prdata_ff <= {8'h00, addr_ff};
          `FEC_OFF_DATA: prdata_ff <= {16'h0000, data_ff};
          `FEC_OFF_CFG: prdata_ff <= {29'h00000000, cfg_ff};
          `FEC_OFF_STAT: prdata_ff <= {25'h0000000, mode_ff, 1'b0,
            timer_ff, refused_ff, busy_ff};
          `FEC_OFF_RDATA: prdata_ff <= {16'h0000, rword};
          default: pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  fec_bus_cycle u_cycle (
    .sys_clk(sys_clk),
    .rst(rst),
    .req_valid(issue_ff),
    .req(req),
    .ack_ff(ack),
    .rdata_ff(rword),
    .fl_addr_ff(fl_addr_ff),
    .fl_dq_o_ff(fl_dq_o_ff),
    .fl_dq_i(fl_dq_i),
    .fl_dq_oe_n_ff(fl_dq_oe_n_ff),
    .fl_ce_n_ff(fl_ce_n_ff),
    .fl_we_n_ff(fl_we_n_ff),
    .fl_oe_n_ff(fl_oe_n_ff)
  );

endmodule : fec_host
`default_nettype wire

// File: verif/fec_host_asserts.sv
// Port checker for the flash erase host controller, bound into fec_host.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fec_host_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  input wire logic pslverr_ff,
  // Flash pins
  input wire logic [23:0] fl_addr_ff,
  input wire logic fl_dq_oe_n_ff,
  input wire logic fl_ce_n_ff,
  input wire logic fl_we_n_ff,
  input wire logic fl_oe_n_ff,
  input wire logic fl_wp_high_ff,
  input wire logic fl_high_program_voltage_ff
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Strobe low 18 cycles, then 5 cycles of hold before dq is let go
  sequence s_we_pulse;
    (!fl_we_n_ff)[*8] ##1 (!fl_we_n_ff)[*8] ##1 (!fl_we_n_ff)[*2]
      ##1 fl_we_n_ff;
  endsequence
  sequence s_recover;
    (!fl_dq_oe_n_ff)[*5] ##1 fl_dq_oe_n_ff;
  endsequence
  chk_apb_answer: assert property (psel && penable && !pready_ff
    |=> pready_ff) else $error("access phase not two cycles");
  chk_ready_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside answer");
  chk_write_pins: assert property (!fl_we_n_ff
    |-> fl_oe_n_ff && !fl_ce_n_ff && !fl_dq_oe_n_ff)
    else $error("write strobe without select or drive");
  chk_read_pins: assert property (!fl_oe_n_ff
    |-> fl_dq_oe_n_ff && !fl_ce_n_ff) else $error("read strobe clash");
  chk_we_len: assert property ($fell(fl_we_n_ff) |-> s_we_pulse)
    else $error("write strobe length wrong");
  chk_dq_recover: assert property ($rose(fl_we_n_ff) |-> s_recover)
    else $error("data hold after write wrong");
  chk_addr_hold: assert property ($fell(fl_ce_n_ff)
    |=> $stable(fl_addr_ff)[*8]) else $error("address moved in cycle");
  chk_hv_wp: assert property (fl_high_program_voltage_ff
    |-> fl_wp_high_ff) else $error("high voltage with protect low");
endmodule : fec_host_chk
bind fec_host fec_host_chk chk_i (
  .sys_clk, .rst, .psel, .penable, .prdata_ff, .pready_ff, .pslverr_ff,
  .fl_addr_ff, .fl_dq_oe_n_ff, .fl_ce_n_ff, .fl_we_n_ff, .fl_oe_n_ff,
  .fl_wp_high_ff, .fl_high_program_voltage_ff
);
`default_nettype wire

// File: verif/fec_flash_model.sv
// Behavioural flash erase engine as seen at its pins, in bypass mode.
// Assumes pins move on sys_clk edges; lowest block is the boundary one.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_model #(
  parameter int SEL_CYC = 300,
  parameter int ERS_CYC = 400
) (
  // Clock
  input wire logic sys_clk,
  // Flash pins
  input wire logic [23:0] addr,
  input wire logic [15:0] dq,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic wp_high,
  input wire logic hv,
  output logic [15:0] dq_out
);
  typedef enum logic [2:0] {FM_RD, FM_SEL, FM_ERS, FM_SUS, FM_CHP, FM_BLK,
    FM_ERR} fec_fm_e;
  fec_fm_e st = FM_RD;
  // Blocks 2, 6 and 7 start programmed
  logic [255:0] blank = ~256'hC4;
  logic [255:0] sel = '0;
  logic [7:0] prev = 8'h00;
  logic [7:0] bblk = 8'h00;
  logic we_q = 1'b1;
  logic ce_q = 1'b1;
  logic [15:0] last = 16'h0000;
  int tmr = 0;
  wire logic [7:0] blk = addr[23:16];
  wire logic [7:0] cmd = dq[7:0];
  wire logic prot = !wp_high && blk == 8'h00;
  wire logic [15:0] poll = {10'h0, st == FM_ERR, 1'b0, st != FM_SEL, 3'h0};
  wire logic arr = st == FM_RD || (st == FM_SUS && !sel[blk]);
  wire logic [15:0] val = arr ? {16{blank[blk]}} : poll;
  wire logic drv = !ce_n && !oe_n;
  // Released bus shows the inverse of the last word, never a stale copy
  assign dq_out = drv ? val : ~last;
  always @(posedge sys_clk) begin
    we_q <= we_n;
    ce_q <= ce_n;
    tmr <= tmr + 1;
    if (drv) begin
      last <= val;
    end
    // Chip select rises with the write strobe, so use its delayed copy
    if (!ce_q && we_n && !we_q) begin
      prev <= cmd;
      case (st)
        FM_RD: if (prev == 8'h80 && cmd == 8'h30 && !prot) begin
          sel[blk] <= 1'b1;
          st <= FM_SEL;
          tmr <= 0;
        end else if (prev == 8'h80 && cmd == 8'h10 && hv) begin
          st <= FM_CHP;
          tmr <= 0;
        end else if (prev == 8'h76 && cmd == 8'h29) begin
          st <= FM_BLK;
          bblk <= blk;
          tmr <= 0;
        end
        FM_SEL: if (cmd == 8'h30) begin
          sel[blk] <= !prot;
          tmr <= 0;
        end else if (cmd == 8'hB0) begin
          st <= FM_SUS;
        end else begin
          st <= FM_RD;
          sel <= '0;
        end
        FM_ERS: if (cmd == 8'hB0) begin
          st <= FM_SUS;
        end
        FM_SUS: if (cmd == 8'h30 && prev != 8'h80) begin
          st <= FM_ERS;
          tmr <= 0;
        end
        FM_ERR: if (cmd == 8'hF0) begin
          st <= FM_RD;
        end
        default: ;
      endcase
    end else begin
      case (st)
        FM_SEL: if (tmr >= SEL_CYC) begin
          st <= FM_ERS;
          tmr <= 0;
        end
        FM_ERS, FM_CHP: if (tmr >= ERS_CYC) begin
          blank <= blank | (st == FM_CHP ? '1 : sel);
          sel <= '0;
          st <= FM_RD;
        end
        FM_BLK: if (tmr >= 20) begin
          st <= blank[bblk] ? FM_RD : FM_ERR;
        end
        default: ;
      endcase
    end
  end
endmodule : fec_flash_model
`default_nettype wire

// File: verif/fec_host_tb.sv
// Self-checking bench for the flash erase host controller.
// Assumes the flash model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "fec_regs.svh"
module flash_erase_blank_check_protect_test import fec_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_ff, q;
  logic pready_ff, pslverr_ff, err;
  logic [23:0] fl_addr_ff;
  logic [15:0] fl_dq_o_ff, fl_dq_i, dq_model;
  logic fl_dq_oe_n_ff, fl_ce_n_ff, fl_we_n_ff, fl_oe_n_ff, fl_wp_high_ff;
  logic fl_high_program_voltage_ff;
  int error_cnt = 0;
  int n_tests = 0;
  assign fl_dq_i = fl_dq_oe_n_ff ? dq_model : fl_dq_o_ff;
  fec_host uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_ff, .pready_ff, .pslverr_ff, .fl_addr_ff, .fl_dq_o_ff, .fl_dq_i,
    .fl_dq_oe_n_ff, .fl_ce_n_ff, .fl_we_n_ff, .fl_oe_n_ff, .fl_wp_high_ff,
    .fl_high_program_voltage_ff);
  fec_flash_model fm (.sys_clk, .addr(fl_addr_ff), .dq(fl_dq_i),
    .ce_n(fl_ce_n_ff), .we_n(fl_we_n_ff), .oe_n(fl_oe_n_ff),
    .wp_high(fl_wp_high_ff), .hv(fl_high_program_voltage_ff),
    .dq_out(dq_model));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready_ff !== 1'b1);
    q = prdata_ff;
    err = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input fec_op_e o, input logic [23:0] a);
    apb(1'b1, `FEC_OFF_ADDR, {8'h00, a});
    apb(1'b1, `FEC_OFF_CTRL, {28'h0, o});
    do begin
      apb(1'b0, `FEC_OFF_STAT, 32'h0);
    end while (q[0] !== 1'b0);
  endtask : op
  task automatic rd_fl(input logic [7:0] b, input logic [15:0] exp);
    op(FEC_OP_READ, {b, 16'h0000});
    apb(1'b0, `FEC_OFF_RDATA, 32'h0);
    chk(q, {16'h0000, exp});
  endtask : rd_fl
  task automatic sts(input logic [2:0] m, input logic t, input logic r);
    apb(1'b0, `FEC_OFF_STAT, 32'h0);
    chk({25'h0, q[6:0]}, {25'h0, m, 1'b0, t, r, 1'b0});
  endtask : sts
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b0, `FEC_OFF_CFG, 32'h0);
    chk(q, 32'h1);
    sts(3'h0, 1'b0, 1'b0);
    apb(1'b0, 12'h018, 32'h0);
    chk({err, q[30:0]}, 32'h80000000);
    // Two-block erase, suspended and resumed inside the selection window
    op(FEC_OP_ERASE_FIRST, 24'h020000);
    sts(3'h1, 1'b0, 1'b0);
    rd_fl(8'h02, 16'h0000);
    op(FEC_OP_ERASE_ADD, 24'h030000);
    op(FEC_OP_SUSPEND, 24'h000000);
    sts(3'h3, 1'b0, 1'b0);
    rd_fl(8'h02, 16'h0008);
    rd_fl(8'h05, 16'hFFFF);
    op(FEC_OP_RESUME, 24'h000000);
    rd_fl(8'h03, 16'h0008);
    sts(3'h2, 1'b1, 1'b0);
    repeat (500) @(posedge sys_clk);
    op(FEC_OP_RESET, 24'h000000);
    rd_fl(8'h02, 16'hFFFF);
    rd_fl(8'h03, 16'hFFFF);
    op(FEC_OP_ERASE_FIRST, 24'h060000);
    op(FEC_OP_RESET, 24'h000000);
    sts(3'h0, 1'b0, 1'b0);
    rd_fl(8'h06, 16'h0000);
    op(FEC_OP_BLANK, 24'h070000);
    sts(3'h5, 1'b0, 1'b0);
    rd_fl(8'h01, 16'h0028);
    op(FEC_OP_RESET, 24'h000000);
    rd_fl(8'h07, 16'h0000);
    op(FEC_OP_BLANK, 24'h050000);
    rd_fl(8'h05, 16'hFFFF);
    op(FEC_OP_RESET, 24'h000000);
    // Boundary block with the protect pin low
    apb(1'b1, `FEC_OFF_CFG, 32'h0);
    op(FEC_OP_ERASE_FIRST, 24'h000000);
    sts(3'h0, 1'b1, 1'b1);
    chk({31'h0, fl_wp_high_ff}, 32'h0);
    apb(1'b1, `FEC_OFF_STAT, 32'h2);
    sts(3'h0, 1'b1, 1'b0);
    apb(1'b1, `FEC_OFF_CFG, 32'h2);
    op(FEC_OP_CHIP, 24'h000000);
    chk({30'h0, fl_high_program_voltage_ff, fl_wp_high_ff}, 32'h3);
    op(FEC_OP_SUSPEND, 24'h000000);
    sts(3'h4, 1'b1, 1'b1);
    repeat (500) @(posedge sys_clk);
    op(FEC_OP_RESET, 24'h000000);
    rd_fl(8'h07, 16'hFFFF);
    test_done();
  end
endmodule : flash_erase_blank_check_protect_test
`default_nettype wire
